//--- rtl/lpcc_ctrl.sv
// low-power clocking mode controller with axi4-lite register slave
// Contract
// RULE1 - partial stop chosen by stop control register, from normal or low-power run
// RULE2 - bus-alive partial stop gates core and system clocks only
// RULE3 - bus-alive partial stop exits on reset, async system irq or bus irq
// RULE4 - all-gated partial stop gates system and bus clocks, all modules stopped
// RULE5 - all-gated partial stop exits only on reset or async irq
// RULE6 - enabled dma request leaves partial stop for transfer then returns
// RULE7 - dma wake-up enabled per channel in compute-only and all stop modes
// RULE8 - dma wake from stop restores clocks and stop lines, core clock stays off
// RULE9 - dma wake in compute-only opens clocks, core clock always on there
// RULE10 - after dma, re-enter by stopping masters then slaves, then power blocks
// RULE11 - dma request that never negates keeps device awake until full exit
// RULE12 - dma request during entry aborts it, sets abort flag, entry restarts later
// RULE13 - irq during dma wake exits at once; optional in compute-only mode
// RULE14 - compute-only keeps cpu running and stops other masters and slaves
// RULE15 - compute-only reuses stop entry, masters stopped before slaves
// RULE16 - compute-only makes bridge space error, private space stays reachable
// RULE17 - compute-only disables flash register interface, power blocks untouched
// RULE18 - compute-only register writable by cpu only; request bit starts entry/exit
// RULE19 - compute-only optionally exits on irq; core and edge irqs need no exit
// RULE20 - ack set when entry completes; clears at once or after low-power delay
// RULE21 - dma wake in compute-only clears ack and opens bridge, then returns
// RULE22 - doze during wait, stop and compute-only including entry and dma wake
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`include "lpcc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module lpcc_ctrl #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // write originator qualifier
  input wire logic wr_from_cpu,
  // cpu state
  input wire logic cpu_wait,
  input wire logic cpu_deep_sleep,
  // wake sources
  input wire logic irq_async,
  input wire logic irq_sys_async,
  input wire logic irq_bus_sync,
  input wire logic irq_level,
  input wire logic [NCH-1:0] dma_req,
  input wire logic dma_done,
  // handshakes from stopped parties
  input wire logic masters_stop_ack,
  input wire logic slaves_stop_ack,
  input wire logic power_stop_ack,
  // clock and stop controls
  output logic core_clk_gate,
  output logic sys_clk_gate,
  output logic bus_clk_gate,
  output logic master_stop_req,
  output logic slave_stop_req,
  output logic bus_slave_stop_req,
  output logic clkgen_stop,
  output logic pmc_stop,
  output logic bridge_error,
  output logic flash_reg_disable,
  output logic periph_doze
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int EXIT_CYC = `LPCC_VLP_EXIT_CYCLES;

  lpcc_pkg::lpcc_state_t state;
  lpcc_pkg::lpcc_state_t next_state;
  lpcc_pkg::lpcc_kind_t kind;
  lpcc_pkg::lpcc_kind_t next_kind;
  logic [1:0] stop_sel;
  logic vlp_run;
  logic cpo_req;
  logic cpo_irq_exit;
  logic [NCH-1:0] dma_wake_en;
  logic stop_abort;
  logic [5:0] exit_cnt;
  logic irq_async_m;
  logic irq_async_s;
  logic irq_sys_m;
  logic irq_sys_s;
  logic [NCH-1:0] dma_m;
  logic [NCH-1:0] dma_s;
  logic dma_hit;
  logic irq_wake;
  logic abort_set;
  logic cpo_auto_clr;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_cpu_q;
  logic do_wr;
  logic wr_ok;
  logic cpo_wr;

  ////////////////////////////////////////////////////////////////////////////
  // async wake sources pass two flops before any use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_async_m <= 1'b0;
      irq_async_s <= 1'b0;
      irq_sys_m <= 1'b0;
      irq_sys_s <= 1'b0;
      dma_m <= '0;
      dma_s <= '0;
    end else begin
      irq_async_m <= irq_async;
      irq_async_s <= irq_async_m;
      irq_sys_m <= irq_sys_async;
      irq_sys_s <= irq_sys_m;
      dma_m <= dma_req;
      dma_s <= dma_m;
    end
  end

  assign dma_hit = |(dma_s & dma_wake_en); // RULE7

  // wake interrupt depends on mode kind and stop variant
  always_comb begin
    if (kind == lpcc_pkg::KIND_CPO) begin
      irq_wake = cpo_irq_exit & irq_level; // RULE19
    end else if (stop_sel == `LPCC_STOP_BUS_ALIVE) begin
      irq_wake = irq_sys_s | irq_bus_sync; // RULE3
    end else begin
      irq_wake = irq_async_s; // RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencer
  always_comb begin
    next_state = state;
    next_kind = kind;
    abort_set = 1'b0;
    cpo_auto_clr = 1'b0;
    unique case (state)
      lpcc_pkg::ST_RUN: begin
        if (cpo_req) begin
          next_state = lpcc_pkg::ST_ENT_MST; // RULE18
          next_kind = lpcc_pkg::KIND_CPO;
        end else if (cpu_deep_sleep) begin
          next_state = lpcc_pkg::ST_ENT_MST; // RULE1
          next_kind = lpcc_pkg::KIND_STOP;
        end
      end
      lpcc_pkg::ST_ENT_MST, lpcc_pkg::ST_ENT_SLV, lpcc_pkg::ST_ENT_PWR: begin
        if (kind == lpcc_pkg::KIND_CPO && !cpo_req) begin
          next_state = lpcc_pkg::ST_RUN;
        end else if (irq_wake) begin
          next_state = lpcc_pkg::ST_RUN;
          cpo_auto_clr = (kind == lpcc_pkg::KIND_CPO);
        end else if (dma_hit) begin
          next_state = lpcc_pkg::ST_DMA_WAKE; // RULE12
          abort_set = 1'b1; // RULE12
        end else if (state == lpcc_pkg::ST_ENT_MST && masters_stop_ack) begin
          next_state = lpcc_pkg::ST_ENT_SLV; // RULE15
        end else if (state == lpcc_pkg::ST_ENT_SLV && slaves_stop_ack) begin
          if (kind == lpcc_pkg::KIND_STOP && stop_sel == `LPCC_STOP_FULL) begin
            next_state = lpcc_pkg::ST_ENT_PWR; // RULE10
          end else begin
            next_state = lpcc_pkg::ST_LOWP;
          end
        end else if (state == lpcc_pkg::ST_ENT_PWR && power_stop_ack) begin
          next_state = lpcc_pkg::ST_LOWP;
        end
      end
      lpcc_pkg::ST_LOWP: begin
        if (kind == lpcc_pkg::KIND_CPO && !cpo_req) begin
          // low-power run needs time for the regulator before bridge opens
          next_state = vlp_run ? lpcc_pkg::ST_EXIT_DLY : lpcc_pkg::ST_RUN; // RULE20
        end else if (irq_wake) begin
          next_state = lpcc_pkg::ST_RUN; // RULE3 RULE5
          cpo_auto_clr = (kind == lpcc_pkg::KIND_CPO);
        end else if (dma_hit) begin
          next_state = lpcc_pkg::ST_DMA_WAKE; // RULE6 RULE8 RULE9
        end
      end
      lpcc_pkg::ST_DMA_WAKE: begin
        if (kind == lpcc_pkg::KIND_CPO && !cpo_req) begin
          next_state = lpcc_pkg::ST_RUN;
        end else if (irq_wake) begin
          next_state = lpcc_pkg::ST_RUN; // RULE13
          cpo_auto_clr = (kind == lpcc_pkg::KIND_CPO);
        end else if (!dma_hit && dma_done) begin
          // a request that never drops holds us here until full exit
          next_state = lpcc_pkg::ST_ENT_MST; // RULE10 RULE11
        end
      end
      lpcc_pkg::ST_EXIT_DLY: begin
        if (exit_cnt == 6'(EXIT_CYC - 1)) begin
          next_state = lpcc_pkg::ST_RUN; // RULE20
        end
      end
      default: begin
        next_state = lpcc_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= lpcc_pkg::ST_RUN;
      kind <= lpcc_pkg::KIND_STOP;
    end else begin
      state <= next_state;
      kind <= next_kind;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exit_cnt <= '0;
    end else if (state == lpcc_pkg::ST_EXIT_DLY) begin
      exit_cnt <= exit_cnt + 6'h01;
    end else begin
      exit_cnt <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs decoded from next state so every pin leaves a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_clk_gate <= 1'b0;
      sys_clk_gate <= 1'b0;
      bus_clk_gate <= 1'b0;
      master_stop_req <= 1'b0;
      slave_stop_req <= 1'b0;
      bus_slave_stop_req <= 1'b0;
      clkgen_stop <= 1'b0;
      pmc_stop <= 1'b0;
      bridge_error <= 1'b0;
      flash_reg_disable <= 1'b0;
      periph_doze <= 1'b0;
    end else begin
      // core clock off in stop, also through dma wake; always on in compute-only
      core_clk_gate <= next_kind == lpcc_pkg::KIND_STOP &&
        (next_state == lpcc_pkg::ST_LOWP || next_state == lpcc_pkg::ST_ENT_PWR ||
         next_state == lpcc_pkg::ST_DMA_WAKE); // RULE2 RULE8 RULE9
      sys_clk_gate <= next_kind == lpcc_pkg::KIND_STOP &&
        (next_state == lpcc_pkg::ST_LOWP || next_state == lpcc_pkg::ST_ENT_PWR); // RULE2 RULE4
      bus_clk_gate <= next_kind == lpcc_pkg::KIND_STOP && stop_sel != `LPCC_STOP_BUS_ALIVE &&
        (next_state == lpcc_pkg::ST_LOWP || next_state == lpcc_pkg::ST_ENT_PWR); // RULE4
      master_stop_req <= next_state != lpcc_pkg::ST_RUN &&
        next_state != lpcc_pkg::ST_DMA_WAKE; // RULE14 RULE15
      slave_stop_req <= next_state == lpcc_pkg::ST_ENT_SLV ||
        next_state == lpcc_pkg::ST_ENT_PWR || next_state == lpcc_pkg::ST_LOWP ||
        next_state == lpcc_pkg::ST_EXIT_DLY; // RULE15
      bus_slave_stop_req <= (next_kind == lpcc_pkg::KIND_CPO ||
        stop_sel != `LPCC_STOP_BUS_ALIVE) &&
        (next_state == lpcc_pkg::ST_ENT_SLV || next_state == lpcc_pkg::ST_ENT_PWR ||
         next_state == lpcc_pkg::ST_LOWP || next_state == lpcc_pkg::ST_EXIT_DLY); // RULE2
      clkgen_stop <= next_kind == lpcc_pkg::KIND_STOP && stop_sel == `LPCC_STOP_FULL &&
        (next_state == lpcc_pkg::ST_ENT_PWR || next_state == lpcc_pkg::ST_LOWP); // RULE4 RULE10
      pmc_stop <= next_kind == lpcc_pkg::KIND_STOP && stop_sel == `LPCC_STOP_FULL &&
        (next_state == lpcc_pkg::ST_ENT_PWR || next_state == lpcc_pkg::ST_LOWP); // RULE17
      bridge_error <= next_kind == lpcc_pkg::KIND_CPO &&
        next_state != lpcc_pkg::ST_RUN && next_state != lpcc_pkg::ST_DMA_WAKE; // RULE16 RULE21
      flash_reg_disable <= next_kind == lpcc_pkg::KIND_CPO &&
        next_state != lpcc_pkg::ST_RUN && next_state != lpcc_pkg::ST_DMA_WAKE; // RULE17
      periph_doze <= cpu_wait || next_state != lpcc_pkg::ST_RUN; // RULE22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data caught in either order
  assign do_wr = aw_held && w_held && !bvalid;
  assign wr_ok = aw_addr_q == `LPCC_OFS_STOPCTRL || aw_addr_q == `LPCC_OFS_DMAWAKE ||
    aw_addr_q == `LPCC_OFS_STATUS || (aw_addr_q == `LPCC_OFS_CPO && aw_cpu_q);
  assign cpo_wr = do_wr && aw_addr_q == `LPCC_OFS_CPO && aw_cpu_q && w_strb_q[0]; // RULE18

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      aw_addr_q <= '0;
      aw_cpu_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid <= 1'b0;
      bresp <= `LPCC_RESP_OKAY;
    end else begin
      awready <= !aw_held && !awready && !bvalid;
      wready <= !w_held && !wready && !bvalid;
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= {awaddr[3:2], 2'h0};
        aw_cpu_q <= wr_from_cpu;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `LPCC_RESP_OKAY : `LPCC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // software-written control; only low byte lanes carry fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_sel <= `LPCC_STOP_FULL;
      vlp_run <= 1'b0;
      dma_wake_en <= '0;
    end else if (do_wr && w_strb_q[0]) begin
      if (aw_addr_q == `LPCC_OFS_STOPCTRL) begin
        stop_sel <= w_data_q[`LPCC_STOPCTRL_SEL_HI:`LPCC_STOPCTRL_SEL_LO]; // RULE1
        vlp_run <= w_data_q[`LPCC_STOPCTRL_VLP];
      end
      if (aw_addr_q == `LPCC_OFS_DMAWAKE) begin
        dma_wake_en <= w_data_q[NCH-1:0]; // RULE7
      end
    end
  end

  // request bit: auto exit clears it unless the cpu sets it in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpo_req <= 1'b0;
      cpo_irq_exit <= 1'b0;
    end else if (cpo_wr) begin
      cpo_req <= w_data_q[`LPCC_CPO_REQ];
      cpo_irq_exit <= w_data_q[`LPCC_CPO_IRQ_EXIT];
    end else if (cpo_auto_clr) begin
      cpo_req <= 1'b0; // RULE19
    end
  end

  // abort flag: hardware set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_abort <= 1'b0;
    end else if (abort_set) begin
      stop_abort <= 1'b1; // RULE12
    end else if (do_wr && aw_addr_q == `LPCC_OFS_STATUS && w_strb_q[1] &&
                 w_data_q[`LPCC_STATUS_ABORT]) begin
      stop_abort <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `LPCC_RESP_OKAY;
    end else begin
      arready <= !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= `LPCC_RESP_OKAY;
        rdata <= '0;
        unique case ({araddr[3:2], 2'h0})
          `LPCC_OFS_STOPCTRL: begin
            rdata[`LPCC_STOPCTRL_SEL_HI:`LPCC_STOPCTRL_SEL_LO] <= stop_sel;
            rdata[`LPCC_STOPCTRL_VLP] <= vlp_run;
          end
          `LPCC_OFS_CPO: begin
            rdata[`LPCC_CPO_REQ] <= cpo_req;
            rdata[`LPCC_CPO_ACK] <= (state == lpcc_pkg::ST_LOWP ||
              state == lpcc_pkg::ST_EXIT_DLY) && kind == lpcc_pkg::KIND_CPO; // RULE20 RULE21
            rdata[`LPCC_CPO_IRQ_EXIT] <= cpo_irq_exit;
          end
          `LPCC_OFS_DMAWAKE: begin
            rdata[NCH-1:0] <= dma_wake_en;
          end
          `LPCC_OFS_STATUS: begin
            rdata[`LPCC_STATUS_STATE_HI:`LPCC_STATUS_STATE_LO] <= state;
            rdata[`LPCC_STATUS_ABORT] <= stop_abort;
            rdata[`LPCC_STATUS_DOZE] <= periph_doze;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // lpcc_ctrl
`default_nettype wire

//--- rtl/lpcc_regs.svh
// register map, field positions and timing constants of the low-power clocking controller
`ifndef LPCC_REGS_SVH
`define LPCC_REGS_SVH
`define LPCC_OFS_STOPCTRL 4'h0
`define LPCC_OFS_CPO 4'h4
`define LPCC_OFS_DMAWAKE 4'h8
`define LPCC_OFS_STATUS 4'hc
`define LPCC_STOP_FULL 2'h0
`define LPCC_STOP_ALL_GATED 2'h1
`define LPCC_STOP_BUS_ALIVE 2'h2
`define LPCC_STOPCTRL_SEL_LO 0
`define LPCC_STOPCTRL_SEL_HI 1
`define LPCC_STOPCTRL_VLP 2
`define LPCC_CPO_REQ 0
`define LPCC_CPO_ACK 1
`define LPCC_CPO_IRQ_EXIT 2
`define LPCC_STATUS_STATE_LO 0
`define LPCC_STATUS_STATE_HI 7
`define LPCC_STATUS_ABORT 8
`define LPCC_STATUS_DOZE 9
`define LPCC_RESP_OKAY 2'h0
`define LPCC_RESP_SLVERR 2'h2
`define LPCC_CLK_PERIOD_NS 50
`define LPCC_VLP_EXIT_DELAY_NS 1000
`define LPCC_VLP_EXIT_CYCLES \
  ((`LPCC_VLP_EXIT_DELAY_NS + `LPCC_CLK_PERIOD_NS - 1) / `LPCC_CLK_PERIOD_NS)
`endif

//--- rtl/lpcc_pkg.sv
// types of the low-power clocking controller
package lpcc_pkg;
  typedef enum logic [7:0] {
    ST_RUN      = 8'h01,
    ST_ENT_MST  = 8'h02,
    ST_ENT_SLV  = 8'h04,
    ST_ENT_PWR  = 8'h08,
    ST_LOWP     = 8'h10,
    ST_DMA_WAKE = 8'h20,
    ST_EXIT_DLY = 8'h40,
    ST_SPARE    = 8'h80
  } lpcc_state_t;
  typedef enum logic {
    KIND_STOP = 1'b0,
    KIND_CPO  = 1'b1
  } lpcc_kind_t;
endpackage

//--- testbench/lpcc_ctrl_monitor.sv
// port checker for the low-power clocking controller
`timescale 1ns/1ps
`default_nettype none
module lpcc_ctrl_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched inputs
  input wire logic cpu_wait,
  input wire logic irq_async,
  input wire logic irq_bus_sync,
  // watched outputs
  input wire logic core_clk_gate,
  input wire logic sys_clk_gate,
  input wire logic bus_clk_gate,
  input wire logic master_stop_req,
  input wire logic slave_stop_req,
  input wire logic bridge_error,
  input wire logic periph_doze
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_gate_needs_stop: assert property (sys_clk_gate |-> master_stop_req && slave_stop_req)
    else $error("system clock gated without stop requests");
  a_bus_gate_order: assert property (bus_clk_gate |-> sys_clk_gate && core_clk_gate)
    else $error("bus clock gated while system or core clock runs");
  a_masters_first: assert property ($rose(slave_stop_req) |-> master_stop_req)
    else $error("slaves asked to stop before masters");
  a_doze_in_stop: assert property (master_stop_req |-> periph_doze)
    else $error("doze low during stop sequence");
  a_cpo_core_runs: assert property (bridge_error |-> !core_clk_gate && !sys_clk_gate)
    else $error("clock gated in compute-only mode");
  a_wait_doze: assert property (cpu_wait ##1 cpu_wait |-> periph_doze)
    else $error("doze low while cpu waits");
  a_bus_alive_exit: assert property (core_clk_gate && sys_clk_gate && !bus_clk_gate
    && irq_bus_sync |-> ##[1:3] !core_clk_gate) else $error("bus irq did not end stop");
  a_async_exit: assert property (bus_clk_gate && irq_async |-> ##[1:5] !bus_clk_gate)
    else $error("async irq did not end gated stop");
endmodule // lpcc_ctrl_monitor
////////////////////////////////////////////////////////////////////////////////
bind lpcc_ctrl lpcc_ctrl_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .cpu_wait(cpu_wait), .irq_async(irq_async),
  .irq_bus_sync(irq_bus_sync), .core_clk_gate(core_clk_gate), .sys_clk_gate(sys_clk_gate),
  .bus_clk_gate(bus_clk_gate), .master_stop_req(master_stop_req),
  .slave_stop_req(slave_stop_req), .bridge_error(bridge_error), .periph_doze(periph_doze)
);
`default_nettype wire

//--- testbench/lpcc_far_model.sv
// far-side model: stop acknowledges from masters, slaves and power blocks
`timescale 1ns/1ps
`default_nettype none
module lpcc_far_model (
  // clock, reset and pace
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  // stop requests
  input wire logic master_stop_req,
  input wire logic slave_stop_req,
  input wire logic pmc_stop,
  // acknowledges
  output logic masters_stop_ack,
  output logic slaves_stop_ack,
  output logic power_stop_ack
);
  logic [3:0] m_sh, s_sh, p_sh;
  // a dropped request drops its ack at once, so no stale ack cuts a later entry short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_sh <= 4'h0;
      s_sh <= 4'h0;
      p_sh <= 4'h0;
    end else begin
      m_sh <= master_stop_req ? {m_sh[2:0], 1'b1} : 4'h0;
      s_sh <= slave_stop_req ? {s_sh[2:0], 1'b1} : 4'h0;
      p_sh <= pmc_stop ? {p_sh[2:0], 1'b1} : 4'h0;
    end
  end
  assign masters_stop_ack = master_stop_req && (slow ? m_sh[3] : m_sh[0]);
  assign slaves_stop_ack = slave_stop_req && (slow ? s_sh[3] : s_sh[0]);
  assign power_stop_ack = pmc_stop && (slow ? p_sh[3] : p_sh[0]);
endmodule // lpcc_far_model
`default_nettype wire

//--- testbench/test_lpcc_ctrl.sv
// self-checking bench for the low-power clocking controller
`include "lpcc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_lpcc_ctrl;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, irqs = 4'h0, dma_req = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, dw;
  logic wr_from_cpu = 1'b0, cpu_wait = 1'b0, cpu_deep_sleep = 1'b0, dma_done = 1'b1, slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, masters_stop_ack, slaves_stop_ack;
  logic power_stop_ack, core_clk_gate, sys_clk_gate, bus_clk_gate, master_stop_req;
  logic slave_stop_req, bus_slave_stop_req, clkgen_stop, pmc_stop, bridge_error;
  logic flash_reg_disable, periph_doze;
  logic [1:0] bresp, rresp;
  logic [10:0] outs;
  logic [1:0] b_q[$];
  logic [33:0] r_q[$];
  int error_cnt = 0, total_checks = 0, cyc = 0, seed = 32'h63c1;
  assign outs = {core_clk_gate, sys_clk_gate, bus_clk_gate, master_stop_req, slave_stop_req,
    bus_slave_stop_req, clkgen_stop, pmc_stop, bridge_error, flash_reg_disable, periph_doze};
  always #25 aclk = ~aclk;
  lpcc_ctrl dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .wr_from_cpu, .cpu_wait, .cpu_deep_sleep,
    .irq_async(irqs[0]), .irq_sys_async(irqs[1]), .irq_bus_sync(irqs[2]), .irq_level(irqs[3]),
    .dma_req, .dma_done, .masters_stop_ack, .slaves_stop_ack, .power_stop_ack, .core_clk_gate,
    .sys_clk_gate, .bus_clk_gate, .master_stop_req, .slave_stop_req, .bus_slave_stop_req,
    .clkgen_stop, .pmc_stop, .bridge_error, .flash_reg_disable, .periph_doze);
  lpcc_far_model far_u (.aclk, .aresetn, .slow, .master_stop_req, .slave_stop_req, .pmc_stop,
    .masters_stop_ack, .slaves_stop_ack, .power_stop_ack);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string n, input logic [33:0] e, input logic [33:0] g);
    error_cnt++;
    $display("MISMATCH %s expected %h seen %h", n, e, g);
  endtask
  // masked compare: bits the hand-over leaves open are not judged
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] m);
    total_checks++;
    if ((outs & m) !== (e & m)) fail(n, {23'h0, e}, {23'h0, outs});
  endtask
  task automatic wait_bit(input int k, input logic v);
    logic hit;
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      hit = outs[k] === v;
      n++;
    end while (!hit && n < 80);
    @(posedge aclk);
    total_checks++;
    if (!hit) fail("wait_bit", {33'h0, v}, {33'h0, outs[k]});
  endtask
  // handshakes are sampled mid-cycle, where registered outputs are settled
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er,
      input logic cpu);
    logic aw_t, w_t, b_t;
    int n;
    b_q.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h3;
    wr_from_cpu <= cpu;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
    end while (!b_t && n < 50);
    if (!b_t) fail("bvalid", 34'h1, 34'h0);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e);
    logic ar_t, r_t;
    int n;
    r_q.push_back({2'h0, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      n++;
    end while (!r_t && n < 50);
    if (!r_t) fail("rvalid", 34'h1, 34'h0);
  endtask
  // enter a stop flavour, try a non-waking irq, then wake with the proper one
  task automatic stop_cycle(input logic [31:0] sel, input logic [3:0] nw, input logic [3:0] w,
      input logic [10:0] e);
    axi_wr(`LPCC_OFS_STOPCTRL, sel, `LPCC_RESP_OKAY, 1'b1);
    cpu_deep_sleep <= 1'b1;
    wait_bit(10, 1'b1);
    irqs <= nw;
    repeat (4) @(posedge aclk);
    irqs <= 4'h0;
    repeat (4) @(posedge aclk);
    chk("stop_outs", e, 11'h7fd);
    irqs <= w;
    cpu_deep_sleep <= 1'b0;
    repeat (3) @(posedge aclk);
    irqs <= 4'h0;
    wait_bit(10, 1'b0);
    chk("run_outs", 11'h000, 11'h7ff);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (bvalid && bready && b_q.size() > 0) begin
      total_checks++;
      if (bresp !== b_q[0]) fail("bresp", {32'h0, b_q[0]}, {32'h0, bresp});
      void'(b_q.pop_front());
    end
    if (rvalid && rready && r_q.size() > 0) begin
      total_checks++;
      if ({rresp, rdata} !== r_q[0]) fail("rdata", r_q[0], {rresp, rdata});
      void'(r_q.pop_front());
    end
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_wr(4'h2, 32'h1, `LPCC_RESP_OKAY, 1'b1);
    axi_rd(4'h2, 32'h1);
    axi_wr(`LPCC_OFS_CPO, 32'h1, `LPCC_RESP_SLVERR, 1'b0);
    axi_rd(`LPCC_OFS_CPO, 32'h0);
    dw = ($random(seed) & 32'hc) | 32'h1;
    axi_wr(`LPCC_OFS_DMAWAKE, dw, `LPCC_RESP_OKAY, 1'b1);
    axi_rd(`LPCC_OFS_DMAWAKE, dw);
    slow <= 1'($random(seed));
    stop_cycle(32'h2, 4'h0, 4'h4, 11'h6c1);
    stop_cycle(32'h1, 4'h4, 4'h1, 11'h7e1);
    stop_cycle(32'h0, 4'h4, 4'h1, 11'h7f9);
    axi_wr(`LPCC_OFS_STOPCTRL, 32'h1, `LPCC_RESP_OKAY, 1'b1);
    cpu_deep_sleep <= 1'b1;
    wait_bit(9, 1'b1);
    dma_req <= 4'h2;
    repeat (8) @(posedge aclk);
    chk("dma_disabled", 11'h7e1, 11'h7fd);
    dma_req <= 4'h1;
    dma_done <= 1'b0;
    wait_bit(9, 1'b0);
    chk("dma_wake", 11'h401, 11'h7fd);
    dma_req <= 4'h0;
    dma_done <= 1'b1;
    wait_bit(9, 1'b1);
    repeat (6) @(posedge aclk);
    chk("reentry", 11'h7e1, 11'h7fd);
    dma_req <= 4'h1;
    dma_done <= 1'b0;
    wait_bit(9, 1'b0);
    irqs <= 4'h1;
    cpu_deep_sleep <= 1'b0;
    wait_bit(10, 1'b0);
    irqs <= 4'h0;
    chk("irq_in_dma", 11'h000, 11'h7ff);
    // request held across entry: abort, then stay awake
    slow <= 1'b1;
    cpu_deep_sleep <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("held_awake", 11'h001, 11'h3fd);
    irqs <= 4'h1;
    cpu_deep_sleep <= 1'b0;
    wait_bit(0, 1'b0);
    irqs <= 4'h0;
    dma_req <= 4'h0;
    dma_done <= 1'b1;
    axi_rd(`LPCC_OFS_STATUS, {24'h1, lpcc_pkg::ST_RUN});
    axi_wr(`LPCC_OFS_STATUS, 32'h100, `LPCC_RESP_OKAY, 1'b1);
    axi_rd(`LPCC_OFS_STATUS, {24'h0, lpcc_pkg::ST_RUN});
    // compute-only from normal run, with dma wake and irq exit
    axi_wr(`LPCC_OFS_CPO, 32'h5, `LPCC_RESP_OKAY, 1'b1);
    wait_bit(6, 1'b1);
    repeat (6) @(posedge aclk);
    chk("cpo", 11'h0e7, 11'h7ff);
    axi_rd(`LPCC_OFS_CPO, 32'h7);
    dma_req <= 4'h1;
    dma_done <= 1'b0;
    wait_bit(2, 1'b0);
    chk("cpo_dma", 11'h001, 11'h7fd);
    axi_rd(`LPCC_OFS_CPO, 32'h5);
    dma_req <= 4'h0;
    dma_done <= 1'b1;
    wait_bit(2, 1'b1);
    irqs <= 4'h8;
    wait_bit(2, 1'b0);
    irqs <= 4'h0;
    chk("cpo_exit", 11'h000, 11'h7ff);
    axi_rd(`LPCC_OFS_CPO, 32'h4);
    // low-power run: ack and bridge errors outlast the exit request
    axi_wr(`LPCC_OFS_STOPCTRL, 32'h4, `LPCC_RESP_OKAY, 1'b1);
    axi_wr(`LPCC_OFS_CPO, 32'h1, `LPCC_RESP_OKAY, 1'b1);
    wait_bit(6, 1'b1);
    repeat (6) @(posedge aclk);
    axi_wr(`LPCC_OFS_CPO, 32'h0, `LPCC_RESP_OKAY, 1'b1);
    axi_rd(`LPCC_OFS_CPO, 32'h2);
    repeat (`LPCC_VLP_EXIT_CYCLES - 10) @(posedge aclk);
    chk("vlp_delay", 11'h004, 11'h004);
    wait_bit(2, 1'b0);
    cpu_wait <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("wait_doze", 11'h001, 11'h7ff);
    cpu_wait <= 1'b0;
    end_of_test();
  end
endmodule // test_lpcc_ctrl
`default_nettype wire
